// ===== verilog/coi_control.sv
/*
 cabinet output interlock and sequencing logic: output gating against the
 blower state, uv interlock, alarms, night hold, restart, password, decon
 sequencer and hour meters.
 assumes key, window and airflow pins are asynchronous single levels;
 keys are debounced outside; a retained blower-run flag survives power loss.
*/
// Overview of operation
// - fan relay follows blower key; with sync, only while blower actively runs
// - light from its key; with sync, on only while blower runs
// - 15 V output always on; with sync, only while blower runs
// - accessory outlet always on; with sync, only while blower runs
// - outlet power from its key; with sync, also needs blower running
// - airflow-off option kills all airflow display and alarm functions
// - uv allowed only with window closed, unless any-height option set
// - warm-up alarms suppressed unless option; audible silenceable, visual held
// - silence key mutes audible alarm 15 minutes; no mute if option off
// - night hold: window closed while running gives low speed, message, blink
// - night hold forces light off and locked, blue blinks if light was on at entry, uv still allowed
// - blower restarts after power loss if auto restart, else waits for key
// - password option needs three-key sequence, default blower-hidden-blower, changeable
// - blower hours count all active running including night hold
// - decon runs total time, starting blower at four slots for run time
// - default decon starts at 1:00, 1:30, 2:00 and 2:30
// - decon refused unless sealed, gas connected and blower stopped confirmed
// - decon shows elapsed, next start and finish; silence key aborts
// - alarm relay on while any airflow alarm condition exists
// - uv off when window raised without any-height option, or user timer expires
// - uv hours counted; at 5000 hours fast blink and replace message
// - enter held 3 s opens menu to view and clear uv hours
// - sync outputs stay off while blower is pending
`timescale 1ns/1ns
module coi_control #(
   parameter int unsigned HOLD_CYC  = coi_pkg::HOLD_ENTER_CYC,
   parameter int unsigned SEC_CYC   = coi_pkg::CLK_HZ,
   parameter int unsigned BLINK_CYC = coi_pkg::BLINK_FAST_CYC
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // options
   input  wire coi_pkg::coi_opt_s opt,
   input  wire logic [5:0]       pw_new,
   input  wire logic             pw_load,
   // keys and sensors (asynchronous)
   input  wire logic             blower_key,
   input  wire logic             hidden_key,
   input  wire logic             light_key,
   input  wire logic             outlet_key,
   input  wire logic             uv_key,
   input  wire logic             silence_key,
   input  wire logic             enter_key,
   input  wire logic             window_closed,
   input  wire logic             airflow_fault,
   input  wire logic             warmup_done,
   input  wire logic             blower_was_on,
   // uv user timer and menu
   input  wire logic [15:0]      uv_timer_sec,
   input  wire logic             uv_clear_confirm,
   // decon checklist
   input  wire logic             decon_start,
   input  wire logic             ok_sealed,
   input  wire logic             ok_gas,
   input  wire logic             ok_stopped,
   // outputs
   output coi_pkg::coi_out_s     out_q,
   output coi_pkg::coi_ind_s     ind_q,
   output logic                  blower_run_q,
   output logic                  blower_low_q,
   output logic                  access_q,
   output logic                  menu_q,
   output logic                  decon_q,
   output logic [15:0]           decon_elapsed_q,
   output logic [15:0]           decon_next_q,
   output logic [15:0]           decon_left_q,
   output logic [31:0]           blower_sec_q,
   output logic [31:0]           uv_sec_q
);
   // refuse counters too short to make a tick or a hold at elaboration
   if (HOLD_CYC < 2 || SEC_CYC < 2 || BLINK_CYC < 2) begin : g_bad_counts
      $error("coi_control: counts too small");
   end

   // two-flop synchronisers for all key and sensor pins
   localparam int NIN = 11;
   logic [NIN-1:0] s1_q, s2_q, p_q;
   always_ff @(posedge ref_clk) begin
      s1_q <= {blower_key, hidden_key, light_key, outlet_key, uv_key, silence_key,
               enter_key, window_closed, airflow_fault, warmup_done, blower_was_on};
      s2_q <= s1_q;
      p_q  <= s2_q;
   end
   wire [NIN-1:0] rise = s2_q & ~p_q;
   wire k_blow = rise[10], k_hid = rise[9], k_light = rise[8], k_out = rise[7];
   wire k_uv = rise[6], k_sil = rise[5], enter_lv = s2_q[4], win = s2_q[3];
   wire af = s2_q[2], warm_ok = s2_q[1], was_on = s2_q[0];

   // one-second tick
   logic [31:0] tick_cnt_q;
   logic        tick;
   always_ff @(posedge ref_clk) begin
      if (!rst_n || tick_cnt_q == SEC_CYC - 1) tick_cnt_q <= 32'h0;
      else tick_cnt_q <= tick_cnt_q + 32'h1;
   end
   assign tick = (tick_cnt_q == SEC_CYC - 1);

   // blink
   logic [31:0] blink_cnt_q;
   logic        blink_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blink_cnt_q <= 32'h0;
         blink_q     <= 1'b0;
      end else if (blink_cnt_q == BLINK_CYC - 1) begin
         blink_cnt_q <= 32'h0;
         blink_q     <= ~blink_q;
      end else blink_cnt_q <= blink_cnt_q + 32'h1;
   end

   // blower state: pending until warm-up done, then active
   typedef enum logic [1:0] {B_OFF, B_PEND, B_RUN} coi_blow_e;
   coi_blow_e blow_q;
   logic      restart_seen_q;
   logic      decon_blow;
   wire       running = (blow_q == B_RUN);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blow_q         <= B_OFF;
         restart_seen_q <= 1'b0;
      end else begin
         restart_seen_q <= 1'b1;
         unique case (blow_q)
            B_OFF:  if (k_blow || decon_blow || (!restart_seen_q && was_on && opt.auto_restart))
                       blow_q <= B_PEND;
            B_PEND: if (k_blow && !decon_q) blow_q <= B_OFF;
                    else if (warm_ok) blow_q <= B_RUN;
            B_RUN:  if ((k_blow && !decon_q) || (decon_q && !decon_blow)) blow_q <= B_OFF;
         endcase
      end
   end

   // night hold
   wire night = opt.night_hold_en && running && win;

   // key toggles
   logic light_sel_q, outlet_sel_q, light_lost_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         light_sel_q  <= 1'b0;
         outlet_sel_q <= 1'b0;
         light_lost_q <= 1'b0;
      end else begin
         if (night) begin
            if (light_sel_q) light_lost_q <= 1'b1;
            light_sel_q <= 1'b0;
         end else begin
            if (k_light) light_sel_q <= ~light_sel_q;
            if (!(opt.night_hold_en && running && win)) light_lost_q <= 1'b0;
         end
         if (k_out) outlet_sel_q <= ~outlet_sel_q;
      end
   end

   // uv lamp with window interlock and user timer
   logic        uv_on_q;
   logic [15:0] uv_tmr_q;
   wire uv_ok = win || opt.uv_any_height;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         uv_on_q  <= 1'b0;
         uv_tmr_q <= 16'h0;
      end else if (!uv_ok) uv_on_q <= 1'b0;
      else if (k_uv) begin
         uv_on_q  <= ~uv_on_q;
         uv_tmr_q <= uv_timer_sec;
      end else if (uv_on_q && tick && uv_tmr_q != 16'h0) begin
         uv_tmr_q <= uv_tmr_q - 16'h1;
         if (uv_tmr_q == 16'h1) uv_on_q <= 1'b0;
      end
   end

   // alarms
   logic [15:0] sil_q;
   wire warm_alarm = (blow_q == B_PEND) && opt.warmup_alarm;
   wire af_alarm   = !opt.airflow_off && ((running && af) || warm_alarm);
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !af_alarm) sil_q <= 16'h0;
      else if (k_sil && opt.silence_en && !decon_q)
         sil_q <= 16'(coi_pkg::SILENCE_SEC);
      else if (tick && sil_q != 16'h0) sil_q <= sil_q - 16'h1;
   end

   // password: shift register of last three blower or hidden keys
   logic [5:0] pw_q, hist_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pw_q     <= coi_pkg::PW_DEFAULT;
         hist_q   <= 6'h3f;
         access_q <= 1'b0;
      end else begin
         if (pw_load) pw_q <= pw_new;
         if (k_blow || k_hid) hist_q <= {hist_q[3:0], k_hid ? 2'h1 : 2'h0};
         access_q <= !opt.password_en || access_q || (hist_q == pw_q);
      end
   end

   // hour meters and enter-hold menu
   logic [31:0] hold_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hold_q <= 32'h0;
         menu_q <= 1'b0;
      end else begin
         hold_q <= enter_lv ? ((hold_q == HOLD_CYC) ? hold_q : hold_q + 32'h1) : 32'h0;
         if (hold_q == HOLD_CYC - 1) menu_q <= 1'b1;
         else if (k_sil) menu_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blower_sec_q <= 32'h0;
         uv_sec_q     <= 32'h0;
      end else begin
         if (tick && running) blower_sec_q <= blower_sec_q + 32'h1;
         if (menu_q && uv_clear_confirm) uv_sec_q <= 32'h0;
         else if (tick && uv_on_q) uv_sec_q <= uv_sec_q + 32'h1;
      end
   end
   wire uv_worn = uv_sec_q >= 32'(coi_pkg::UV_LIMIT_HR * coi_pkg::SEC_PER_HR);

   // decon sequencer, times in seconds
   function automatic logic [15:0] slot_sec(input logic [1:0] i);
      unique case (i)
         2'h0: slot_sec = 16'(coi_pkg::DECON_START0_MIN * coi_pkg::SEC_PER_MIN);
         2'h1: slot_sec = 16'(coi_pkg::DECON_START1_MIN * coi_pkg::SEC_PER_MIN);
         2'h2: slot_sec = 16'(coi_pkg::DECON_START2_MIN * coi_pkg::SEC_PER_MIN);
         default: slot_sec = 16'(coi_pkg::DECON_START3_MIN * coi_pkg::SEC_PER_MIN);
      endcase
   endfunction : slot_sec
   localparam logic [15:0] TOTAL_S = 16'(coi_pkg::DECON_TOTAL_MIN * coi_pkg::SEC_PER_MIN);
   localparam logic [15:0] RUN_S   = 16'(coi_pkg::DECON_RUN_SEC);
   logic [1:0] slot_q;
   logic       slots_done_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         decon_q <= 1'b0;
         decon_elapsed_q <= 16'h0;
         slot_q <= 2'h0;
         slots_done_q <= 1'b0;
      end else if (!decon_q) begin
         decon_elapsed_q <= 16'h0;
         slot_q <= 2'h0;
         slots_done_q <= 1'b0;
         if (decon_start && ok_sealed && ok_gas && ok_stopped && blow_q == B_OFF)
            decon_q <= 1'b1;
      end else if (k_sil || decon_elapsed_q >= TOTAL_S) decon_q <= 1'b0;
      else if (tick) begin
         decon_elapsed_q <= decon_elapsed_q + 16'h1;
         if (!slots_done_q && decon_elapsed_q + 16'h1 == slot_sec(slot_q) + RUN_S) begin
            if (slot_q == 2'(coi_pkg::DECON_SLOTS - 1)) slots_done_q <= 1'b1;
            else slot_q <= slot_q + 2'h1;
         end
      end
   end
   assign decon_blow = decon_q && !slots_done_q && decon_elapsed_q >= slot_sec(slot_q)
                       && decon_elapsed_q < slot_sec(slot_q) + RUN_S;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         decon_next_q <= 16'h0;
         decon_left_q <= 16'h0;
      end else begin
         if (slots_done_q || !decon_q) decon_next_q <= 16'h0;
         else if (decon_elapsed_q < slot_sec(slot_q))
            decon_next_q <= slot_sec(slot_q) - decon_elapsed_q;
         // a slot whose run has begun counts as started: show the following one
         else if (slot_q != 2'(coi_pkg::DECON_SLOTS - 1))
            decon_next_q <= slot_sec(slot_q + 2'h1) - decon_elapsed_q;
         else decon_next_q <= 16'h0;
         decon_left_q <= decon_q ? TOTAL_S - decon_elapsed_q : 16'h0;
      end
   end

   // output gating, recomputed every cycle; sync gates exclude pending, blower_run_q includes it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         out_q <= '0;
         ind_q <= '0;
         blower_run_q <= 1'b0;
         blower_low_q <= 1'b0;
      end else begin
         out_q.fan_relay  <= (blow_q != B_OFF) && (!opt.sync_fan || running);
         out_q.light      <= light_sel_q && !night && (!opt.sync_light || running);
         out_q.dc15       <= !opt.sync_dc15 || running;
         out_q.acc_outlet <= !opt.sync_acc || running;
         out_q.outlet     <= outlet_sel_q && (!opt.sync_outlet || running);
         out_q.uv_lamp    <= uv_on_q && uv_ok;
         out_q.alarm_relay <= af_alarm;
         out_q.audible    <= af_alarm && sil_q == 16'h0;
         out_q.visual     <= af_alarm;
         ind_q.blower_green <= running ? (night ? blink_q : 1'b1)
                                       : (blow_q == B_PEND) && blink_q;
         ind_q.light_blue <= night ? (light_lost_q && blink_q) : light_sel_q;
         ind_q.uv_yellow  <= uv_worn ? blink_q : uv_on_q;
         ind_q.msg_night_hold <= night;
         ind_q.msg_replace_uv <= uv_worn;
         ind_q.msg_power_reset <= !restart_seen_q ? 1'b1
                                  : (ind_q.msg_power_reset && !(|rise[10:4]));
         blower_run_q <= blow_q != B_OFF;
         blower_low_q <= night;
      end
   end
endmodule : coi_control

// ===== verilog/coi_pkg.sv
/*
 package for the cabinet output interlock block: timing constants,
 reset values, option and status carriers.
 assumes a 100 MHz ref_clk.
*/
package coi_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   // times in their own units, counts derived from them
   localparam int unsigned SEC_PER_MIN   = 60;
   localparam int unsigned SILENCE_MIN   = 15;
   localparam int unsigned SILENCE_SEC   = SILENCE_MIN * SEC_PER_MIN;
   localparam int unsigned HOLD_ENTER_S  = 3;
   localparam int unsigned HOLD_ENTER_CYC = HOLD_ENTER_S * CLK_HZ;
   localparam int unsigned UV_LIMIT_HR   = 5000;
   localparam int unsigned SEC_PER_HR    = 3600;
   localparam int unsigned PW_LEN        = 3;
   // decon defaults in minutes / seconds
   localparam int unsigned DECON_TOTAL_MIN = 180;
   localparam int unsigned DECON_RUN_SEC   = 60;
   localparam int unsigned DECON_START0_MIN = 60;
   localparam int unsigned DECON_START1_MIN = 90;
   localparam int unsigned DECON_START2_MIN = 120;
   localparam int unsigned DECON_START3_MIN = 150;
   localparam int unsigned DECON_SLOTS   = 4;
   // fast blink divider: a quarter second
   localparam int unsigned BLINK_FAST_CYC = CLK_HZ / 4;
   localparam int unsigned BLINK_SLOW_CYC = CLK_HZ;

   // key codes for the password sequence
   typedef enum logic [1:0] {KEY_BLOWER, KEY_HIDDEN, KEY_OTHER} coi_key_e;
   localparam logic [5:0] PW_DEFAULT = {2'h0, 2'h1, 2'h0}; // blower, hidden, blower

   typedef struct packed {
      logic sync_fan;
      logic sync_light;
      logic sync_dc15;
      logic sync_acc;
      logic sync_outlet;
      logic airflow_off;
      logic uv_any_height;
      logic warmup_alarm;
      logic silence_en;
      logic night_hold_en;
      logic auto_restart;
      logic password_en;
   } coi_opt_s;

   typedef struct packed {
      logic fan_relay;
      logic light;
      logic dc15;
      logic acc_outlet;
      logic outlet;
      logic uv_lamp;
      logic alarm_relay;
      logic audible;
      logic visual;
   } coi_out_s;

   typedef struct packed {
      logic blower_green;
      logic light_blue;
      logic uv_yellow;
      logic msg_night_hold;
      logic msg_replace_uv;
      logic msg_power_reset;
   } coi_ind_s;
endpackage : coi_pkg

// ===== testbench/coi_control_assertions.sv
/* checker for coi_control: port-level relations between options, blower
   state and outputs. assumes only the top ports; bound at the foot. */
`timescale 1ns/1ns
module coi_control_chk (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rst_n,
   // inputs watched
   input wire coi_pkg::coi_opt_s opt,
   input wire logic              window_closed,
   input wire logic              decon_start,
   input wire logic              ok_sealed,
   input wire logic              ok_gas,
   input wire logic              ok_stopped,
   // outputs watched
   input wire coi_pkg::coi_out_s out_q,
   input wire logic              blower_run_q,
   input wire logic              blower_low_q,
   input wire logic              decon_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic oks = ok_sealed & ok_gas & ok_stopped;
   // the window pin passes a two-flop synchroniser, so allow five edges
   sequence s_win_open;
      (!window_closed)[*5];
   endsequence
   sequence s_decon_ask;
      decon_start && !decon_q;
   endsequence
   fan_sync_gate_a:
      assert property ((opt.sync_fan && !blower_run_q)[*3] |-> !out_q.fan_relay)
      else $error("fan relay on while blower off under sync");
   light_sync_gate_a:
      assert property ((opt.sync_light && !blower_run_q)[*3] |-> !out_q.light)
      else $error("light on while blower off under sync");
   dc15_free_a:
      assert property ((!opt.sync_dc15)[*3] |-> out_q.dc15)
      else $error("dc output off without sync");
   acc_free_a:
      assert property ((!opt.sync_acc)[*3] |-> out_q.acc_outlet)
      else $error("accessory outlet off without sync");
   outlet_sync_gate_a:
      assert property ((opt.sync_outlet && !blower_run_q)[*3] |-> !out_q.outlet)
      else $error("outlet on while blower off under sync");
   airflow_off_quiet_a:
      assert property ((opt.airflow_off)[*3] |->
         !(out_q.alarm_relay || out_q.audible || out_q.visual))
      else $error("airflow alarm active while monitoring off");
   uv_window_lock_a:
      assert property (s_win_open and (!opt.uv_any_height)[*5] |-> !out_q.uv_lamp)
      else $error("uv lamp on with window open");
   hold_needs_close_a:
      assert property (s_win_open |-> !blower_low_q)
      else $error("night hold with window open");
   hold_needs_run_a:
      assert property (blower_low_q |-> $past(blower_run_q))
      else $error("night hold without blower");
   hold_light_off_a:
      assert property (blower_low_q[*2] |-> !out_q.light)
      else $error("light on during night hold");
   decon_refuse_a:
      assert property (s_decon_ask and !oks |=> !decon_q)
      else $error("decon started without checklist");
   decon_accept_a:
      assert property (s_decon_ask and oks && !blower_run_q |=> decon_q)
      else $error("decon not started with checklist met");
endmodule : coi_control_chk

bind coi_control coi_control_chk u_chk (.ref_clk, .rst_n, .opt, .window_closed,
   .decon_start, .ok_sealed, .ok_gas, .ok_stopped, .out_q, .blower_run_q,
   .blower_low_q, .decon_q);

// ===== testbench/coi_panel.sv
/* operator keypad model: a requested key pin rises and stays up while
   requested plus three cycles, as a slow finger would. assumes the bench
   raises requests just after a clock edge. */
`timescale 1ns/1ns
module coi_panel (
   // clock
   input  wire logic       ref_clk,
   // requests and key pins
   input  wire logic [6:0] press,
   output logic [6:0]      pins
);
   logic [6:0] s1_q, s2_q, s3_q;
   // the tail keeps each press long enough for the pin synchroniser
   always_ff @(posedge ref_clk) begin
      s1_q <= press;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   assign pins = press | s1_q | s2_q | s3_q;
endmodule : coi_panel

// ===== testbench/coi_control_test.sv
/* self-checking bench for coi_control: keys through the panel model,
   options and sensors driven directly; second and hold counts shortened. */
`timescale 1ns/1ns
module coi_control_test;
   localparam int K_BLOW = 0, K_HID = 1, K_LIGHT = 2, K_OUT = 3;
   localparam int K_UV = 4, K_SIL = 5, K_ENT = 6;
   logic              ref_clk = 1'b0;
   logic              rst_n = 1'b0;
   coi_pkg::coi_opt_s opt = '0;
   logic [6:0]        press = 7'h00;
   logic [6:0]        pins;
   logic              win = 1'b0, fault = 1'b0, warm = 1'b0, was_on = 1'b0;
   logic              dstart = 1'b0;
   logic [2:0]        oks = 3'h0;
   coi_pkg::coi_out_s out;
   coi_pkg::coi_ind_s ind;
   logic              run, low, acc, menu, dq;
   logic [15:0]       el, nx, lf;
   logic [31:0]       bsec, t, usec;
   logic [15:0]       uvt = 16'h0000;
   logic              uv_clr = 1'b0, pw_ld = 1'b0;
   logic [5:0]        pw_nw = 6'h00;
   int                fails = 0, checks_done = 0, cyc_n = 0;

   coi_panel u_pnl (.ref_clk, .press, .pins);
   coi_control #(.HOLD_CYC(10), .SEC_CYC(10), .BLINK_CYC(4)) DUT (
      .ref_clk, .rst_n, .opt, .pw_new(pw_nw), .pw_load(pw_ld),
      .blower_key(pins[0]), .hidden_key(pins[1]), .light_key(pins[2]),
      .outlet_key(pins[3]), .uv_key(pins[4]), .silence_key(pins[5]),
      .enter_key(pins[6]), .window_closed(win), .airflow_fault(fault),
      .warmup_done(warm), .blower_was_on(was_on), .uv_timer_sec(uvt),
      .uv_clear_confirm(uv_clr), .decon_start(dstart), .ok_sealed(oks[0]),
      .ok_gas(oks[1]), .ok_stopped(oks[2]), .out_q(out), .ind_q(ind),
      .blower_run_q(run), .blower_low_q(low), .access_q(acc), .menu_q(menu),
      .decon_q(dq), .decon_elapsed_q(el), .decon_next_q(nx), .decon_left_q(lf),
      .blower_sec_q(bsec), .uv_sec_q(usec));

   always #5 ref_clk = ~ref_clk;

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   // the decon slot wait dominates the run, about 37000 cycles
   always @(posedge ref_clk) begin
      cyc_n++;
      if (cyc_n == 45000) begin
         fails++;
         finish_test();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   // releases and waits so the synced pin sees a low gap before the next key
   task automatic key(input int k, input int n);
      press[k] = 1'b1;
      cyc(n);
      press[k] = 1'b0;
      cyc(8);
   endtask : key

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   initial begin
      cyc(16);
      rst_n = 1'b1;
      cyc(3);
      check("dc15 free", out.dc15, 1'b1);
      check("acc free", out.acc_outlet, 1'b1);
      opt.sync_dc15 = 1'b1;
      opt.sync_acc = 1'b1;
      opt.warmup_alarm = 1'b1;
      cyc(3);
      check("dc15 sync", out.dc15, 1'b0);
      check("acc sync", out.acc_outlet, 1'b0);
      key(K_BLOW, 2);
      check("fan pending", out.fan_relay, 1'b1);
      check("dc15 pending", out.dc15, 1'b0);
      check("warmup visual", out.visual, 1'b1);
      opt.sync_fan = 1'b1;
      cyc(3);
      check("fan sync pending", out.fan_relay, 1'b0);
      warm = 1'b1;
      cyc(6);
      check("warmup over", out.visual, 1'b0);
      check("fan running", out.fan_relay, 1'b1);
      check("dc15 running", out.dc15, 1'b1);
      check("acc running", out.acc_outlet, 1'b1);
      opt.sync_light = 1'b1;
      opt.sync_outlet = 1'b1;
      key(K_LIGHT, 2);
      check("light", out.light, 1'b1);
      key(K_OUT, 2);
      check("outlet", out.outlet, 1'b1);
      fault = 1'b1;
      cyc(6);
      check("alarm relay", out.alarm_relay, 1'b1);
      key(K_SIL, 2);
      check("no mute", out.audible, 1'b1);
      opt.silence_en = 1'b1;
      key(K_SIL, 2);
      check("muted", out.audible, 1'b0);
      check("relay held", out.alarm_relay, 1'b1);
      opt.airflow_off = 1'b1;
      cyc(3);
      check("airflow off", out.alarm_relay, 1'b0);
      fault = 1'b0;
      opt.airflow_off = 1'b0;
      opt.night_hold_en = 1'b1;
      win = 1'b1;
      cyc(6);
      check("hold", low, 1'b1);
      check("hold msg", ind.msg_night_hold, 1'b1);
      check("hold light", out.light, 1'b0);
      t = bsec;
      cyc(20);
      check("hold hours", bsec - t, 32'h2);
      key(K_LIGHT, 2);
      check("light locked", out.light, 1'b0);
      key(K_UV, 2);
      check("uv in hold", out.uv_lamp, 1'b1);
      win = 1'b0;
      cyc(6);
      check("uv raised", out.uv_lamp, 1'b0);
      check("hold ends", low, 1'b0);
      key(K_UV, 2);
      check("uv refused", out.uv_lamp, 1'b0);
      opt.uv_any_height = 1'b1;
      key(K_UV, 2);
      check("uv any height", out.uv_lamp, 1'b1);
      key(K_BLOW, 2);
      check("fan off", out.fan_relay, 1'b0);
      check("dc15 off", out.dc15, 1'b0);
      t = bsec;
      cyc(20);
      check("idle hours", bsec - t, 32'h0);
      oks = 3'h5;
      dstart = 1'b1;
      cyc(3);
      check("decon refused", dq, 1'b0);
      oks = 3'h7;
      cyc(3);
      dstart = 1'b0;
      check("decon on", dq, 1'b1);
      check("next slot", 32'(el) + 32'(nx), 32'd3600);
      check("finish", 32'(el) + 32'(lf), 32'd10800);
      while (el !== 16'd3600) cyc(1);
      cyc(3);
      check("slot run", run, 1'b1);
      check("slot two", 32'(el) + 32'(nx), 32'd5400);
      cyc(610);
      check("run time", run, 1'b0);
      key(K_SIL, 2);
      check("abort", dq, 1'b0);
      key(K_ENT, 3);
      check("short enter", menu, 1'b0);
      key(K_ENT, 20);
      check("menu", menu, 1'b1);
      uv_clr = 1'b1;
      cyc(2);
      check("uv clear", usec, 32'h0);
      uv_clr = 1'b0;
      uvt = 16'd2;
      key(K_UV, 2);
      key(K_UV, 2);
      check("uv timed on", out.uv_lamp, 1'b1);
      check("uv led", ind.uv_yellow, 1'b1);
      cyc(25);
      check("uv timer", out.uv_lamp, 1'b0);
      // password enabled through reset so access is not already granted
      for (int i = 0; i < 2; i++) begin
         rst_n = 1'b0;
         was_on = 1'b1;
         opt = '0;
         opt.auto_restart = i[0];
         opt.password_en = 1'b1;
         cyc(16);
         rst_n = 1'b1;
         cyc(8);
         check("restart", run, i[0]);
         check("power msg", ind.msg_power_reset, 1'b1);
         check("pw locked", acc, 1'b0);
         pw_nw = 6'h01;
         pw_ld = i[0];
         cyc(1);
         pw_ld = 1'b0;
         key(K_HID, 2);
         key(K_HID, 2);
         key(K_BLOW, 2);
         check("bad password", acc, 1'b0);
         key(K_HID, 2);
         key(K_BLOW, 2);
         check("password", acc, !i[0]);
         key(K_BLOW, 2);
         key(K_BLOW, 2);
         key(K_HID, 2);
         check("new password", acc, 1'b1);
      end
      finish_test();
   end
endmodule : coi_control_test
